// file: core/sbs_sram_port.sv
// ---------------------------------------------------------------
// Synchronous burst SRAM: bus-side control and storage array
// ---------------------------------------------------------------
// Assumes the memory bus master drives all synchronous pins from
// the rising edge of clk_i; output drive, sleep and the two static
// mode pins may arrive from anywhere and are synchronised here.
// A classic Wishbone slave exposes status and a software sleep bit.
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`include "sbs_consts.svh"

module sbs_sram_port
  import sbs_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Synchronous memory bus
  input  wire logic [`SBS_ADDR_W-1:0]    addr_bus_i,
  input  wire logic                      master_select_n_i,
  input  wire logic                      select_hi_i,
  input  wire logic                      select_lo_n_i,
  input  wire logic                      proc_addr_strobe_n_i,
  input  wire logic                      ctrl_addr_strobe_n_i,
  input  wire logic                      burst_advance_n_i,
  input  wire logic                      global_write_n_i,
  input  wire logic                      byte_write_gate_n_i,
  input  wire logic [`SBS_LANES-1:0]     lane_write_n_i,
  // Data pins as input, output and enable
  input  wire logic [`SBS_DATA_W-1:0]    dq_i,
  output logic      [`SBS_DATA_W-1:0]    dq_o,
  output logic                           dq_oe_o,
  // Asynchronous and static pins
  input  wire logic                      out_drive_n_i,
  input  wire logic                      sleep_req_i,
  input  wire logic                      burst_order_sel_i,
  input  wire logic                      flowthru_sel_n_i,
  // Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [31:0]               wb_adr_i,
  input  wire logic [31:0]               wb_dat_i,
  input  wire logic [3:0]                wb_sel_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [`SBS_DATA_W-1:0] mem_r [0:`SBS_DEPTH-1];
  logic [3:0]             meta_r;
  logic [3:0]             sync_r;
  logic                   ctrl_sleep_r;
  sbs_state_t             state_r;
  logic [`SBS_ADDR_W-1:0] base_r;
  logic [1:0]             cnt_r;
  logic [`SBS_DATA_W-1:0] pipe_q_r;
  logic                   pipe_v_r;
  logic                   outv_r;
  sbs_op_t                op;
  logic                   awake;
  logic                   oe_act;
  logic                   order_xor;
  logic                   flow_mode;
  logic                   sel_ok;
  logic                   proc_go;
  logic                   wr_req;
  logic [`SBS_LANES-1:0]  lane_en;
  logic [1:0]             cnt_nxt;
  logic [`SBS_ADDR_W-1:0] acc_addr;
  logic                   do_rd;
  logic                   do_wr;
  logic                   outv_nxt;
  logic                   wb_hit;

  // Low address bits of burst step n from the loaded start bits
  function automatic logic [1:0] burst_lo(input logic [1:0] start,
                                          input logic [1:0] step,
                                          input logic       xor_order);
    burst_lo = xor_order ? (start ^ step) : 2'(start + step);
  endfunction

  // ---------------------------------------------------------------
  // Synchronisers for pins outside the clock's timing
  // ---------------------------------------------------------------
  // Order input idles high so an open pin means interleaved order
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= `SBS_SYNC_RST;
      sync_r <= `SBS_SYNC_RST;
    end else begin
      meta_r <= {flowthru_sel_n_i, burst_order_sel_i, sleep_req_i, out_drive_n_i};
      sync_r <= meta_r;
    end
  end

  assign oe_act    = !sync_r[`SBS_SY_OE_N];
  assign order_xor = sync_r[`SBS_SY_ORDER];
  assign flow_mode = !sync_r[`SBS_SY_FLOW_N];
  // Sleep from the pin or from software freezes the memory bus side; the Wishbone slave keeps running
  assign awake     = !(sync_r[`SBS_SY_SLEEP] || ctrl_sleep_r);

  // ---------------------------------------------------------------
  // Write enable decode
  // ---------------------------------------------------------------
  // Global write overrides the gate and the lane inputs
  always_comb begin
    if (!global_write_n_i) begin
      lane_en = {`SBS_LANES{1'b1}};
    end else if (!byte_write_gate_n_i) begin
      lane_en = ~lane_write_n_i;
    end else begin
      lane_en = '0;
    end
  end

  // A write needs at least one lane; otherwise it is a read
  assign wr_req = |lane_en;

  // ---------------------------------------------------------------
  // Per-edge operation decode
  // ---------------------------------------------------------------
  assign sel_ok  = !master_select_n_i && select_hi_i && !select_lo_n_i;
  assign proc_go = !proc_addr_strobe_n_i && !master_select_n_i;

  // Processor strobe wins over the controller strobe
  always_comb begin
    op = SBS_OP_NONE;
    if (!awake) begin
      op = SBS_OP_NONE;
    end else if (proc_go) begin
      op = sel_ok ? SBS_OP_BEGIN_RD : SBS_OP_DESEL;
    end else if (!ctrl_addr_strobe_n_i) begin
      if (!sel_ok) begin
        op = SBS_OP_DESEL;
      end else if (wr_req) begin
        op = SBS_OP_BEGIN_WR;
      end else begin
        op = SBS_OP_BEGIN_RD;
      end
    end else if (state_r == SBS_BURST) begin
      // Master select does not matter here
      op = burst_advance_n_i ? SBS_OP_HOLD : SBS_OP_NEXT;
    end
  end

  // Address used by this edge's access
  always_comb begin
    cnt_nxt  = cnt_r;
    acc_addr = {base_r[`SBS_ADDR_W-1:2], burst_lo(base_r[1:0], cnt_r, order_xor)};
    if (op == SBS_OP_BEGIN_RD || op == SBS_OP_BEGIN_WR) begin
      cnt_nxt  = 2'h0;
      acc_addr = addr_bus_i;
    end else if (op == SBS_OP_NEXT) begin
      cnt_nxt  = 2'(cnt_r + 2'h1);
      acc_addr = {base_r[`SBS_ADDR_W-1:2], burst_lo(base_r[1:0], cnt_nxt, order_xor)};
    end
  end

  assign do_wr = (op == SBS_OP_BEGIN_WR) ||
                 ((op == SBS_OP_NEXT || op == SBS_OP_HOLD) && wr_req);
  assign do_rd = (op == SBS_OP_BEGIN_RD) ||
                 ((op == SBS_OP_NEXT || op == SBS_OP_HOLD) && !wr_req);

  // ---------------------------------------------------------------
  // Burst state and counter
  // ---------------------------------------------------------------
  // Deselect ends a burst; sleep leaves the position untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= SBS_IDLE;
      base_r  <= '0;
      cnt_r   <= 2'h0;
    end else begin
      unique case (op)
        SBS_OP_BEGIN_RD,
        SBS_OP_BEGIN_WR: begin
          state_r <= SBS_BURST;
          base_r  <= addr_bus_i;
          cnt_r   <= 2'h0;
        end
        SBS_OP_NEXT: begin
          cnt_r <= cnt_nxt;
        end
        SBS_OP_DESEL: begin
          state_r <= SBS_IDLE;
        end
        SBS_OP_HOLD,
        SBS_OP_NONE: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Storage array
  // ---------------------------------------------------------------
  // Not reset: contents survive reset and sleep alike
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      for (int l = 0; l < `SBS_LANES; l++) begin
        if (lane_en[l]) begin
          mem_r[acc_addr][l*`SBS_LANE_W +: `SBS_LANE_W] <= dq_i[l*`SBS_LANE_W +: `SBS_LANE_W];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read pipeline and data pin drive
  // ---------------------------------------------------------------
  // Pipeline stage is frozen while asleep so a suspended burst resumes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pipe_v_r <= 1'b0;
      pipe_q_r <= '0;
    end else if (awake) begin
      pipe_v_r <= do_rd;
      pipe_q_r <= mem_r[acc_addr];
    end
  end

  // Flow-through bypasses the stage; pipelined takes it one edge later
  assign outv_nxt = awake && (flow_mode ? do_rd : pipe_v_r);

  // Output register; drive also needs the synchronised output drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_o    <= '0;
      dq_oe_o <= 1'b0;
      outv_r  <= 1'b0;
    end else begin
      dq_o    <= flow_mode ? mem_r[acc_addr] : pipe_q_r;
      dq_oe_o <= oe_act && outv_nxt;
      outv_r  <= outv_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  // One wait state: ack one edge after the strobe, dropped the next
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  // Software sleep bit; unmapped writes are acked and dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_sleep_r <= `SBS_CTRL_RST;
    end else if (wb_hit && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i[31:4] == 28'h0 && wb_adr_i[3:0] == `SBS_REG_CTRL) begin
      ctrl_sleep_r <= wb_dat_i[`SBS_CTRL_SLEEP];
    end
  end

  // Read data; unmapped addresses read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_hit) begin
      wb_dat_o <= 32'h0;
      if (wb_adr_i[31:4] == 28'h0 && wb_adr_i[3:0] == `SBS_REG_STATUS) begin
        wb_dat_o[`SBS_ST_CNT_LO +: 2] <= cnt_r;
        wb_dat_o[`SBS_ST_ACTIVE]      <= (state_r == SBS_BURST);
        wb_dat_o[`SBS_ST_SLEEP]       <= !awake;
        wb_dat_o[`SBS_ST_ORDER]       <= order_xor;
        wb_dat_o[`SBS_ST_FLOW]        <= flow_mode;
        wb_dat_o[`SBS_ST_OUTV]        <= outv_r;
      end else if (wb_adr_i[31:4] == 28'h0 && wb_adr_i[3:0] == `SBS_REG_CTRL) begin
        wb_dat_o[`SBS_CTRL_SLEEP]     <= ctrl_sleep_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking sbs_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_rd_start_pipe;
    (op == SBS_OP_BEGIN_RD) && !flow_mode && oe_act;
  endsequence

  sequence s_stage_drive;
    awake && oe_act && !flow_mode;
  endsequence

  a_pipe_read_latency: assert property (
    s_rd_start_pipe ##1 s_stage_drive |=> dq_oe_o)
    else $error("pipelined read data not driven one edge later");

  a_flow_first_data: assert property (
    (op == SBS_OP_BEGIN_RD) && flow_mode && oe_act |=> dq_oe_o)
    else $error("flow-through read start did not drive data");

  a_drive_needs_oe: assert property (
    dq_oe_o |-> $past(oe_act) && $past(outv_nxt))
    else $error("data pins driven without output drive or read");

  a_desel_floats: assert property (
    (op == SBS_OP_DESEL) && flow_mode |=> !dq_oe_o)
    else $error("deselect did not float data pins");

  a_burst_step: assert property (
    op == SBS_OP_NEXT |=> cnt_r == 2'($past(cnt_r) + 2'h1) && $stable(base_r))
    else $error("advance did not step the burst counter");

  a_burst_suspend: assert property (
    op == SBS_OP_HOLD |=> $stable(cnt_r) && $stable(base_r) && state_r == SBS_BURST)
    else $error("suspend lost the burst position");

  a_lane_select: assert property (
    global_write_n_i && !byte_write_gate_n_i |-> lane_en == ~lane_write_n_i)
    else $error("lane enables do not follow lane inputs");

  a_global_all: assert property (
    do_wr && !global_write_n_i |-> lane_en == 4'hf)
    else $error("global write did not enable all lanes");

  a_read_no_lanes: assert property (
    (op == SBS_OP_NEXT || op == SBS_OP_HOLD) && lane_en == 4'h0 |-> do_rd && !do_wr)
    else $error("cycle without lane write not treated as read");

  a_proc_ignored: assert property (
    master_select_n_i && ctrl_addr_strobe_n_i && state_r == SBS_IDLE |=>
      state_r == SBS_IDLE)
    else $error("processor strobe acted with master select inactive");

  a_sleep_frozen: assert property (
    !awake |=> $stable(cnt_r) && $stable(state_r) && !dq_oe_o)
    else $error("activity while asleep");

endmodule

// file: core/sbs_consts.svh
// ---------------------------------------------------------------
// Constants of the synchronous burst SRAM port
// ---------------------------------------------------------------
// Offsets, field positions, reset values and sizes shared by the
// design; included by bare name, definitions only.
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH

// Array geometry: 256K words of four 9-bit lanes
`define SBS_ADDR_W     18
`define SBS_DATA_W     36
`define SBS_LANES      4
`define SBS_LANE_W     9
`define SBS_DEPTH      262144

// Register offsets on the control bus (byte addresses)
`define SBS_REG_STATUS 4'h0
`define SBS_REG_CTRL   4'h4

// Control register fields
`define SBS_CTRL_SLEEP 0
`define SBS_CTRL_RST   1'b0

// Status register fields
`define SBS_ST_CNT_LO  0
`define SBS_ST_ACTIVE  2
`define SBS_ST_SLEEP   3
`define SBS_ST_ORDER   4
`define SBS_ST_FLOW    5
`define SBS_ST_OUTV    6

// Synchroniser lanes and their idle values after reset
`define SBS_SY_OE_N    0
`define SBS_SY_SLEEP   1
`define SBS_SY_ORDER   2
`define SBS_SY_FLOW_N  3
`define SBS_SYNC_RST   4'hd

`endif

// file: core/sbs_pkg.sv
// ---------------------------------------------------------------
// Types of the synchronous burst SRAM port
// ---------------------------------------------------------------
// Burst state and per-edge operation decode; no assumptions about
// the surroundings.
package sbs_pkg;

  // Burst tracking state
  typedef enum logic {
    SBS_IDLE,
    SBS_BURST
  } sbs_state_t;

  // Operation decoded on one rising edge
  typedef enum logic [2:0] {
    SBS_OP_NONE,
    SBS_OP_DESEL,
    SBS_OP_BEGIN_RD,
    SBS_OP_BEGIN_WR,
    SBS_OP_NEXT,
    SBS_OP_HOLD
  } sbs_op_t;

endpackage

// file: sim/sbs_bus_model.sv
// Memory controller model driving the synchronous bus of the SRAM port.
// Assumes each step is entered just after a rising edge of clk_i.
`timescale 1ns/1ns
`include "sbs_consts.svh"

module sbs_bus_model
  import sbs_pkg::*;
(
  // Clock and output drive hold-off from the bench
  input  wire logic                   clk_i,
  input  wire logic                   oe_block_i,
  // Synchronous bus towards the port
  output logic [`SBS_ADDR_W-1:0]      addr_bus_o,
  output logic                        master_select_n_o,
  output logic                        select_hi_o,
  output logic                        select_lo_n_o,
  output logic                        proc_addr_strobe_n_o,
  output logic                        ctrl_addr_strobe_n_o,
  output logic                        burst_advance_n_o,
  output logic                        global_write_n_o,
  output logic                        byte_write_gate_n_o,
  output logic [`SBS_LANES-1:0]       lane_write_n_o,
  output logic [`SBS_DATA_W-1:0]      dq_o,
  output logic                        out_drive_n_o
);
  // Idle bus at time zero
  initial begin
    {master_select_n_o, proc_addr_strobe_n_o, ctrl_addr_strobe_n_o} = 3'h7;
    {select_hi_o, select_lo_n_o, burst_advance_n_o, global_write_n_o} = 4'h9;
    {byte_write_gate_n_o, out_drive_n_o} = 2'h2;
    lane_write_n_o = 4'hf;
    addr_bus_o = '0;
    dq_o = '0;
  end

  // One bus cycle: wr 0 read, 1 global write, 2 lane write, 3 foreign strobe
  // with master select high; for deselect wr picks the bad select pattern
  task automatic step(input sbs_op_t op, input logic [1:0] wr, input logic [17:0] a,
                      input logic [35:0] d, input logic [3:0] ln);
    logic ds;
    logic wt;
    ds = op == SBS_OP_DESEL;
    wt = !ds && (wr == 2'h1 || wr == 2'h2);
    master_select_n_o    <= (ds && wr == 2'h0) || wr == 2'h3;
    select_hi_o          <= !(ds && wr == 2'h1);
    select_lo_n_o        <= ds && wr == 2'h2;
    proc_addr_strobe_n_o <= !(op == SBS_OP_BEGIN_RD || wr == 2'h3 || (ds && wr == 2'h1));
    ctrl_addr_strobe_n_o <= !(op == SBS_OP_BEGIN_WR || (ds && wr != 2'h1));
    burst_advance_n_o    <= op != SBS_OP_NEXT;
    global_write_n_o     <= ds || wr != 2'h1;
    byte_write_gate_n_o  <= 1'b0;
    lane_write_n_o       <= wt ? ln : 4'hf;
    addr_bus_o           <= a;
    // Undriven data toggles so stale values never look valid
    dq_o                 <= wt ? d : ~dq_o;
    // Output drive held off whenever write data is on the bus
    out_drive_n_o        <= oe_block_i || wt;
    @(posedge clk_i);
  endtask
endmodule

// file: sim/sync_burst_sram_port_bench.sv
// Self-checking bench of the SRAM port: memory bus bursts and Wishbone.
// Outputs are read at the edge after the one that launched them.
`timescale 1ns/1ns
`include "sbs_consts.svh"

module sync_burst_sram_port_bench
  import sbs_pkg::*;
;
  logic                   clk_i, rst_i, oe_block;
  logic                   sleep_req_i, burst_order_sel_i, flowthru_sel_n_i;
  logic                   wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]             wb_sel_i;
  logic [31:0]            wb_adr_i, wb_dat_i, wb_dat_o, r;
  logic [`SBS_ADDR_W-1:0] addr_bus_i;
  logic                   master_select_n_i, select_hi_i, select_lo_n_i;
  logic                   proc_addr_strobe_n_i, ctrl_addr_strobe_n_i, burst_advance_n_i;
  logic                   global_write_n_i, byte_write_gate_n_i, out_drive_n_i, dq_oe_o;
  logic [`SBS_LANES-1:0]  lane_write_n_i;
  logic [`SBS_DATA_W-1:0] dq_i, dq_o;
  logic [35:0]            sh [0:15];
  int                     failures, num_checks;

  sbs_sram_port u_dut (.clk_i, .rst_i, .addr_bus_i, .master_select_n_i, .select_hi_i,
    .select_lo_n_i, .proc_addr_strobe_n_i, .ctrl_addr_strobe_n_i, .burst_advance_n_i,
    .global_write_n_i, .byte_write_gate_n_i, .lane_write_n_i, .dq_i, .dq_o, .dq_oe_o,
    .out_drive_n_i, .sleep_req_i, .burst_order_sel_i, .flowthru_sel_n_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o);

  sbs_bus_model u_bus (.clk_i, .oe_block_i(oe_block), .addr_bus_o(addr_bus_i),
    .master_select_n_o(master_select_n_i), .select_hi_o(select_hi_i),
    .select_lo_n_o(select_lo_n_i), .proc_addr_strobe_n_o(proc_addr_strobe_n_i),
    .ctrl_addr_strobe_n_o(ctrl_addr_strobe_n_i), .burst_advance_n_o(burst_advance_n_i),
    .global_write_n_o(global_write_n_i), .byte_write_gate_n_o(byte_write_gate_n_i),
    .lane_write_n_o(lane_write_n_i), .dq_o(dq_i), .out_drive_n_o(out_drive_n_i));

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // Compare, bus and burst tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk_q(input bit on, input logic [35:0] e);
    num_checks++;
    if (dq_oe_o !== on || (on && dq_o !== e)) begin
      failures++;
      $display("mismatch dq exp %h/%h got %h/%h", on, e, dq_oe_o, dq_o);
    end
  endtask

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  // Classic single Wishbone cycle; the slave sets the pace
  task automatic wbx(input logic we, input logic [31:0] adr, input logic [31:0] wd);
    int n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, 4'hf};
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
    if (n >= 20) begin
      failures++;
      finish_test();
    end
  endtask

  function automatic logic [17:0] ad(int g, logic [1:0] lo);
    return {16'(16'h5a00 + g), lo};
  endfunction

  function automatic logic [35:0] mrg(logic [35:0] o, logic [35:0] n, logic [3:0] ln);
    for (int l = 0; l < 4; l++) if (!ln[l]) o[9*l +: 9] = n[9*l +: 9];
    return o;
  endfunction

  task automatic idle(input int n);
    repeat (n) u_bus.step(SBS_OP_DESEL, 2'h0, '0, '0, 4'hf);
  endtask

  // Four-beat write burst; the shadow follows the burst order pin
  task automatic wr4(input int g, input logic [1:0] s, input logic [1:0] k,
                     input logic [35:0] d, input logic [3:0] ln, input bit keep);
    logic [1:0] lo;
    for (int i = 0; i < 4; i++) begin
      lo = burst_order_sel_i ? s ^ 2'(i) : s + 2'(i);
      u_bus.step(i == 0 ? SBS_OP_BEGIN_WR : SBS_OP_NEXT, k, i == 0 ? ad(g, s) : ~ad(g, s),
                 d + 36'(i), ln);
      if (keep) sh[{2'(g), lo}] = mrg(sh[{2'(g), lo}], d + 36'(i), k == 2'h1 ? 4'h0 : ln);
    end
    idle(3);
  endtask

  // Read burst from word 0 with a foreign strobe, a suspend, then deselect
  task automatic rd4(input int g, input sbs_op_t op0, input bit on);
    sbs_op_t ops [8] = '{op0, SBS_OP_NEXT, SBS_OP_HOLD, SBS_OP_NEXT, SBS_OP_NEXT,
                         SBS_OP_DESEL, SBS_OP_DESEL, SBS_OP_DESEL};
    int      seq [5] = '{0, 1, 1, 2, 3};
    int      lat;
    lat = int'(flowthru_sel_n_i);
    for (int i = 0; i < 8; i++) begin
      u_bus.step(ops[i], i == 1 ? 2'h3 : 2'h0, i == 0 ? ad(g, 2'h0) : ~ad(g, 2'h0), '0, 4'hf);
      if (i > lat && i - 1 - lat < 5) chk_q(on, sh[{2'(g), 2'(seq[i - 1 - lat])}]);
    end
    chk_q(1'b0, '0);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_i, oe_block, sleep_req_i, burst_order_sel_i, flowthru_sel_n_i} = 5'h13;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = '0;
    {wb_adr_i, wb_dat_i} = '0;
    failures = 0;
    num_checks = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    idle(3);
    wbx(1'b0, 32'h0, 32'h0);
    chk32("status", 32'h10, r);
    wbx(1'b1, 32'h8, 32'hffff_ffff);
    wbx(1'b0, 32'h8, 32'h0);
    chk32("unmapped", 32'h0, r);
    wbx(1'b1, 32'h4, 32'h1);
    wbx(1'b0, 32'h4, 32'h0);
    chk32("ctrl", 32'h1, r);
    wbx(1'b0, 32'h0, 32'h0);
    chk32("asleep", 32'h18, r);
    wbx(1'b1, 32'h4, 32'h0);
    // XOR write from word 1 then linear read back
    wr4(0, 2'h1, 2'h1, 36'h1_2345_6780, 4'h5, 1'b1);
    burst_order_sel_i <= 1'b0;
    idle(3);
    rd4(0, SBS_OP_BEGIN_RD, 1'b1);
    wr4(1, 2'h1, 2'h1, 36'h9_8765_4320, 4'hf, 1'b1);
    wr4(1, 2'h2, 2'h2, 36'h5_5aa5_a5a0, 4'ha, 1'b1);
    burst_order_sel_i <= 1'b1;
    idle(3);
    rd4(1, SBS_OP_BEGIN_WR, 1'b1);
    oe_block <= 1'b1;
    idle(3);
    rd4(0, SBS_OP_BEGIN_RD, 1'b0);
    oe_block <= 1'b0;
    idle(3);
    // Bad secondary selects, or a processor strobe with master select
    // high while no burst runs, must never start a read
    for (int v = 1; v < 4; v++) begin
      u_bus.step(v == 3 ? SBS_OP_NEXT : SBS_OP_DESEL, 2'(v), ad(0, 2'h0), '0, 4'hf);
      idle(2);
      chk_q(1'b0, '0);
    end
    flowthru_sel_n_i <= 1'b0;
    idle(3);
    // Idle after a four-beat burst: step count 3, XOR order, flow-through
    wbx(1'b0, 32'h0, 32'h0);
    chk32("status", 32'h33, r);
    rd4(0, SBS_OP_BEGIN_RD, 1'b1);
    {flowthru_sel_n_i, sleep_req_i} <= 2'h3;
    idle(3);
    wr4(0, 2'h0, 2'h1, 36'h0, 4'h0, 1'b0);
    sleep_req_i <= 1'b0;
    idle(3);
    rd4(0, SBS_OP_BEGIN_RD, 1'b1);
    finish_test();
  end
endmodule
